// ### common/msp_regs.vh
`ifndef MSP_REGS_VH
`define MSP_REGS_VH
// Bit-rate select codes
`define MSP_SPD_2400 3'h0
`define MSP_SPD_4800 3'h1
`define MSP_SPD_9600 3'h2
`define MSP_SPD_19200 3'h3
`define MSP_SPD_38400 3'h4
`define MSP_SPD_57600 3'h5
`define MSP_SPD_115200 3'h6
// Bit rates in bit/s
`define MSP_RATE_2400 2400
`define MSP_RATE_4800 4800
`define MSP_RATE_9600 9600
`define MSP_RATE_19200 19200
`define MSP_RATE_38400 38400
`define MSP_RATE_57600 57600
`define MSP_RATE_115200 115200
// Clock rate in Hz
`define MSP_CLK_HZ 40000000
// Character framing: start + 8 data + stop
`define MSP_DATA_BITS 4'h8
`define MSP_FRAME_BITS 4'ha
// Line control codes
`define MSP_CODE_ENQ 8'h05
`define MSP_CODE_EOT 8'h04
`define MSP_CODE_ACK 8'h06
`define MSP_CODE_NAK 8'h15
// Station byte marker and limits
`define MSP_STN_MARK 8'h80
`define MSP_STN_MAX 5'h1f
`endif

// ### src/msp_fifo.v
`timescale 1ns/100ps
module msp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Fill side
  input wire i_valid,
  input wire [WIDTH-1:0] i_data,
  output wire o_ready,
  // Drain side
  output wire o_valid,
  output wire [WIDTH-1:0] o_data,
  input wire i_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire wr = i_valid && o_ready;
  wire rd = o_valid && i_ready;
  assign o_ready = (cnt_q != DEPTH[AW:0]);
  assign o_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_data = mem[rp_q];
  // Storage, pointers and fill count
  always @(posedge i_mclk) begin
    if (wr) begin
      mem[wp_q] <= i_data;
    end
    if (i_rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (wr) begin
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (wr && !rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (rd && !wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ### src/msp_port.v
`timescale 1ns/100ps
`include "msp_regs.vh"
module msp_port #(
  parameter CLK_HZ = `MSP_CLK_HZ,
  parameter DEPTH = 8
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Configuration straps
  input wire [2:0] i_rs232_speed_select,
  input wire [2:0] i_rs485_speed_select,
  input wire [4:0] i_station_number,
  // RS232 pins
  input wire i_rs232_rxd,
  output reg o_rs232_txd,
  // RS485 pins: shared line, enable low while driving
  input wire i_rs485_rxd,
  output reg o_rs485_txd,
  output reg o_rs485_oe_n,
  // Transmit request from the drive
  input wire i_tx_valid,
  input wire [7:0] i_tx_data,
  input wire i_tx_sel485,
  output reg o_tx_ready,
  // Received characters
  output reg o_rx_valid,
  output reg [7:0] o_rx_data,
  output reg o_rx_from485,
  input wire i_rx_ready,
  // Line code decode of last received character
  output reg o_rx_is_ctrl,
  output reg o_rx_station,
  output reg o_rx_for_me
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  // Bit periods in clock cycles for each rate
  localparam [31:0] DIV_2400 = CLK_HZ / `MSP_RATE_2400;
  localparam [31:0] DIV_4800 = CLK_HZ / `MSP_RATE_4800;
  localparam [31:0] DIV_9600 = CLK_HZ / `MSP_RATE_9600;
  localparam [31:0] DIV_19200 = CLK_HZ / `MSP_RATE_19200;
  localparam [31:0] DIV_38400 = CLK_HZ / `MSP_RATE_38400;
  localparam [31:0] DIV_57600 = CLK_HZ / `MSP_RATE_57600;
  localparam [31:0] DIV_115200 = CLK_HZ / `MSP_RATE_115200;

  // Cycles per bit for a speed code
  function [15:0] bit_cycles;
    input [2:0] code;
    begin
      case (code)
        `MSP_SPD_2400: bit_cycles = DIV_2400[15:0];
        `MSP_SPD_4800: bit_cycles = DIV_4800[15:0];
        `MSP_SPD_9600: bit_cycles = DIV_9600[15:0];
        `MSP_SPD_19200: bit_cycles = DIV_19200[15:0];
        `MSP_SPD_38400: bit_cycles = DIV_38400[15:0];
        `MSP_SPD_57600: bit_cycles = DIV_57600[15:0];
        default: bit_cycles = DIV_115200[15:0];
      endcase
    end
  endfunction

  // Power-on latch of speeds and station number
  reg cfg_done_q;
  reg [15:0] div232_q;
  reg [15:0] div485_q;
  reg [4:0] stn_q;
  always @(posedge i_mclk) begin
    if (i_rst) begin
      cfg_done_q <= 1'b0;
      div232_q <= 16'h0000;
      div485_q <= 16'h0000;
      stn_q <= 5'h00;
    end else if (!cfg_done_q) begin
      cfg_done_q <= 1'b1;
      div232_q <= bit_cycles(i_rs232_speed_select);
      div485_q <= bit_cycles(i_rs485_speed_select);
      stn_q <= i_station_number;
    end
  end

  // Pin synchronisers
  reg [1:0] s232_q;
  reg [1:0] s485_q;
  always @(posedge i_mclk) begin
    if (i_rst) begin
      s232_q <= 2'h3;
      s485_q <= 2'h3;
    end else begin
      s232_q <= {s232_q[0], i_rs232_rxd};
      s485_q <= {s485_q[0], i_rs485_rxd};
    end
  end
  wire rx232 = s232_q[1];
  wire rx485 = s485_q[1];

  // Transmit FIFO; tx selects port per word in bit 8
  wire fifo_valid;
  wire [8:0] fifo_data;
  reg tx_pop;
  reg [4:0] occ_q;
  wire tx_push = i_tx_valid && o_tx_ready;
  wire [4:0] occ_d = occ_q + {4'h0, tx_push} - {4'h0, tx_pop};
  msp_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(3)) u_txf (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_valid(tx_push),
    .i_data({i_tx_sel485, i_tx_data}),
    .o_ready(),
    .o_valid(fifo_valid),
    .o_data(fifo_data),
    .i_ready(tx_pop)
  );
  // Ready follows the next fill level, so an admitted push is never lost
  always @(posedge i_mclk) begin
    if (i_rst) begin
      occ_q <= 5'h00;
      o_tx_ready <= 1'b0;
    end else begin
      occ_q <= occ_d;
      o_tx_ready <= cfg_done_q && (occ_d != DEPTH[4:0]);
    end
  end

  // Receiver results; RS232 runs independently, RS485 only starts while the transmitter is not sending on RS485
  wire [1:0] rdone;
  wire [17:0] rsh_all;
  wire [1:0] rline = {rx485, rx232};
  wire [31:0] rdiv = {div485_q, div232_q};
  // Transmitter state
  reg [1:0] tst_q;
  reg [15:0] tcnt_q;
  reg [3:0] tbit_q;
  reg [9:0] tsh_q;
  reg tport_q;
  wire rs485_rx_en = (tst_q == ST_IDLE) || !tport_q;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_rx
      reg [1:0] st_q;
      reg [15:0] cnt_q;
      reg [3:0] bit_q;
      reg [8:0] sh_q;
      reg done_q;
      // Per-port results gathered into shared buses
      assign rdone[g] = done_q;
      assign rsh_all[g*9 +: 9] = sh_q;
      // Sample mid-bit, shift LSB first, check stop bit
      always @(posedge i_mclk) begin
        done_q <= 1'b0;
        if (i_rst || !cfg_done_q) begin
          st_q <= ST_IDLE;
          cnt_q <= 16'h0000;
          bit_q <= 4'h0;
          sh_q <= 9'h000;
        end else begin
          case (st_q)
            ST_IDLE: begin
              if (!rline[g] && (g == 0 || rs485_rx_en)) begin
                st_q <= ST_SHIFT;
                cnt_q <= {1'b0, rdiv[g*16+1 +: 15]};
                bit_q <= 4'h0;
              end
            end
            ST_SHIFT: begin
              if (cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 1'b1;
              end else begin
                cnt_q <= rdiv[g*16 +: 16] - 1'b1;
                bit_q <= bit_q + 1'b1;
                if (bit_q == 4'h0 && rline[g]) begin
                  st_q <= ST_IDLE; // False start
                end else if (bit_q != 4'h0) begin
                  sh_q <= {rline[g], sh_q[8:1]};
                end
                if (bit_q == `MSP_FRAME_BITS - 1'b1) begin
                  st_q <= ST_IDLE;
                  done_q <= rline[g];
                end
              end
            end
            default: st_q <= ST_IDLE;
          endcase
        end
      end
    end
  endgenerate

  // Finished byte, RS232 first, and the RS485 byte for station decode
  wire [7:0] rx_byte = rdone[0] ? rsh_all[7:0] : rsh_all[16:9];
  wire [7:0] b485 = rsh_all[16:9];
  // Output holding register with handshake and code decode
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_from485 <= 1'b0;
      o_rx_is_ctrl <= 1'b0;
      o_rx_station <= 1'b0;
      o_rx_for_me <= 1'b0;
    end else if (rdone != 2'h0 && (!o_rx_valid || i_rx_ready)) begin
      o_rx_valid <= 1'b1;
      o_rx_from485 <= !rdone[0];
      o_rx_data <= rx_byte;
      o_rx_is_ctrl <= rx_byte == `MSP_CODE_ENQ || rx_byte == `MSP_CODE_EOT ||
                      rx_byte == `MSP_CODE_ACK || rx_byte == `MSP_CODE_NAK;
      o_rx_station <= rdone[0] ? 1'b0 : b485[7];
      o_rx_for_me <= !rdone[0] && b485[7] && b485[4:0] == stn_q;
    end else if (i_rx_ready) begin
      o_rx_valid <= 1'b0;
    end
  end

  // Transmitter; RS485 driver enabled only during its character
  always @(posedge i_mclk) begin
    tx_pop <= 1'b0;
    if (i_rst || !cfg_done_q) begin
      tst_q <= ST_IDLE;
      tcnt_q <= 16'h0000;
      tbit_q <= 4'h0;
      tsh_q <= 10'h3ff;
      tport_q <= 1'b0;
      o_rs232_txd <= 1'b1;
      o_rs485_txd <= 1'b1;
      o_rs485_oe_n <= 1'b1;
    end else begin
      case (tst_q)
        ST_IDLE: begin
          o_rs485_oe_n <= 1'b1;
          if (fifo_valid && !tx_pop) begin
            tx_pop <= 1'b1;
            tst_q <= ST_SHIFT;
            tport_q <= fifo_data[8];
            tsh_q <= {1'b1, fifo_data[7:0], 1'b0};
            tbit_q <= 4'h0;
            tcnt_q <= (fifo_data[8] ? div485_q : div232_q) - 1'b1;
          end
        end
        ST_SHIFT: begin
          if (tport_q) begin
            o_rs485_oe_n <= 1'b0;
            o_rs485_txd <= tsh_q[0];
          end else begin
            o_rs232_txd <= tsh_q[0];
          end
          if (tcnt_q != 16'h0000) begin
            tcnt_q <= tcnt_q - 1'b1;
          end else begin
            tcnt_q <= (tport_q ? div485_q : div232_q) - 1'b1;
            tsh_q <= {1'b1, tsh_q[9:1]};
            tbit_q <= tbit_q + 1'b1;
            if (tbit_q == `MSP_FRAME_BITS - 1'b1) begin
              tst_q <= ST_IDLE;
              o_rs232_txd <= 1'b1;
              o_rs485_txd <= 1'b1;
            end
          end
        end
        default: tst_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// ### tb/msp_port_properties.sv
`timescale 1ns/100ps
module msp_port_checker (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Watched ports
  input wire i_rx_ready,
  input wire o_rs232_txd,
  input wire o_rs485_txd,
  input wire o_rs485_oe_n,
  input wire o_tx_ready,
  input wire o_rx_valid,
  input wire [7:0] o_rx_data,
  input wire o_rx_from485,
  input wire o_rx_is_ctrl,
  input wire o_rx_station,
  input wire o_rx_for_me
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_rst_idle;
    disable iff (1'b0) i_rst |=> o_rs232_txd && o_rs485_oe_n && !o_rx_valid && !o_tx_ready;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset idle");
  property p_rx_hold;
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx hold");
  property p_one_tx;
    !o_rs485_oe_n |-> o_rs232_txd;
  endproperty
  a_one_tx: assert property (p_one_tx) else $error("two drivers");
  property p_drv_start;
    $fell(o_rs485_oe_n) |-> !o_rs485_txd;
  endproperty
  a_drv_start: assert property (p_drv_start) else $error("drive start");
  property p_ctrl;
    o_rx_valid |-> o_rx_is_ctrl == (o_rx_data inside {8'h05, 8'h04, 8'h06, 8'h15});
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl decode");
  property p_stn;
    o_rx_valid && o_rx_station |-> o_rx_data[7] && o_rx_from485;
  endproperty
  a_stn: assert property (p_stn) else $error("station mark");
  property p_stn232;
    o_rx_valid && !o_rx_from485 |-> !o_rx_station && !o_rx_for_me;
  endproperty
  a_stn232: assert property (p_stn232) else $error("station on 232");
  property p_me;
    o_rx_valid && o_rx_for_me |-> o_rx_station;
  endproperty
  a_me: assert property (p_me) else $error("match");
endmodule
bind msp_port msp_port_checker u_chk (.*);

// ### tb/msp_host_model.sv
`timescale 1ns/100ps
module msp_host_model (
  // Clock
  input wire i_mclk,
  // Lines
  input wire i_rs232_line,
  input wire i_rs485_line,
  output logic o_rs232_drv = 1'b1,
  output logic o_rs485_drv = 1'b1
);
  // Send start, 8 data LSB first, stop
  task automatic send(input logic p, input logic [7:0] c, input int bc);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_mclk);
      if (p) o_rs485_drv <= f[i];
      else o_rs232_drv <= f[i];
      repeat (bc - 1) @(posedge i_mclk);
    end
  endtask
  // Sample mid-bit; returns stop level
  task automatic recv(input logic p, input int bc, output logic [7:0] c, output logic s);
    while ((p ? i_rs485_line : i_rs232_line) !== 1'b0) @(posedge i_mclk);
    repeat (bc / 2) @(posedge i_mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bc) @(posedge i_mclk);
      s = p ? i_rs485_line : i_rs232_line;
      if (i < 8) c[i] = s;
    end
  endtask
endmodule

// ### tb/tb_multidrop_serial_host_port.sv
`timescale 1ns/100ps
module tb_multidrop_serial_host_port;
  localparam int HZ = 1152000;
  // Axis switch pause, shortened to keep the run short
  localparam int AXIS_GAP = HZ / 400;
  int rates[7] = '{2400, 4800, 9600, 19200, 38400, 57600, 115200};
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] s2 = 3'h0;
  logic [2:0] s4 = 3'h0;
  logic [4:0] stn = 5'h00;
  logic tv = 1'b0;
  logic [7:0] td = 8'h00;
  logic tsel = 1'b0;
  logic rr = 1'b0;
  wire t2, t4, oe_n, trdy, rv, f4, ic, is, me, h2, h4;
  wire [7:0] rd;
  // RS485 wire: device drive wins, host otherwise
  wire l4 = oe_n ? h4 : t4;
  msp_port #(.CLK_HZ(HZ)) dut_u (.i_mclk(clk), .i_rst(rst), .i_rs232_speed_select(s2),
    .i_rs485_speed_select(s4), .i_station_number(stn), .i_rs232_rxd(h2), .o_rs232_txd(t2),
    .i_rs485_rxd(l4), .o_rs485_txd(t4), .o_rs485_oe_n(oe_n), .i_tx_valid(tv), .i_tx_data(td),
    .i_tx_sel485(tsel), .o_tx_ready(trdy), .o_rx_valid(rv), .o_rx_data(rd), .o_rx_from485(f4),
    .i_rx_ready(rr), .o_rx_is_ctrl(ic), .o_rx_station(is), .o_rx_for_me(me));
  msp_host_model host_u (.i_mclk(clk), .i_rs232_line(t2), .i_rs485_line(l4), .o_rs232_drv(h2),
    .o_rs485_drv(h4));
  // Clock and watchdog
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      finish_test();
    end
  end
  task automatic check(input string w, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset, then move straps after the latch edge
  task automatic do_reset(input logic [2:0] a, input logic [2:0] b, input logic [4:0] s);
    @(posedge clk);
    rst <= 1'b1;
    s2 <= a;
    s4 <= b;
    stn <= s;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    s2 <= ~a;
    s4 <= ~b;
    stn <= ~s;
  endtask
  task automatic xfer(input logic p, input logic [7:0] d, input int bc);
    logic [7:0] c;
    logic s;
    do @(negedge clk); while (trdy !== 1'b1);
    @(posedge clk);
    tv <= 1'b1;
    tsel <= p;
    td <= d;
    @(posedge clk);
    tv <= 1'b0;
    host_u.recv(p, bc, c, s);
    check("tx char", d, c);
    check("tx stop", 8'h01, {7'h0, s});
  endtask
  task automatic take_rx(input logic p, input logic [7:0] d, input int bc, input logic [3:0] f);
    // Host waits for the RS485 driver to turn around first
    do @(posedge clk); while (oe_n !== 1'b1);
    host_u.send(p, d, bc);
    do @(negedge clk); while (rv !== 1'b1);
    repeat (2) @(negedge clk);
    check("rx char", d, rd);
    check("rx flags", {4'h0, f}, {4'h0, f4, ic, is, me});
    @(posedge clk);
    rr <= 1'b1;
    @(posedge clk);
    rr <= 1'b0;
  endtask
  // Every speed code, RS485 at the mirrored code 6 - k, so both ports share one speed at code 3
  task automatic t_rates();
    for (int k = 0; k < 7; k++) begin
      do_reset(k[2:0], 3'(6 - k), 5'h00);
      xfer(1'b0, 8'ha5 ^ k[7:0], HZ / rates[k]);
      xfer(1'b1, 8'h3c + k[7:0], HZ / rates[6 - k]);
      take_rx(1'b1, 8'h5a, HZ / rates[6 - k], 4'h8);
      take_rx(1'b0, 8'hc3, HZ / rates[k], 4'h0);
    end
  endtask
  // Line codes and station bytes, station 5
  task automatic t_codes();
    logic [12:0] tb[8] = '{13'h105c, 13'h185b, 13'h104c, 13'h19fa, 13'h0064, 13'h0154, 13'h0410, 13'h185b};
    do_reset(3'h6, 3'h6, 5'h05);
    foreach (tb[i]) begin
      if (i == 3) repeat (AXIS_GAP) @(posedge clk);
      take_rx(tb[i][12], tb[i][11:4], 10, tb[i][3:0]);
    end
  endtask
  // Fill the queue until refused while the host drains it in order
  task automatic t_fifo();
    logic [7:0] c;
    logic s;
    int n;
    int i;
    bit filled;
    n = 0;
    i = 0;
    filled = 1'b0;
    do_reset(3'h6, 3'h6, 5'h01);
    fork
      begin
        do @(negedge clk); while (trdy !== 1'b1);
        @(posedge clk);
        tsel <= 1'b0;
        tv <= 1'b1;
        td <= 8'h40;
        @(negedge clk);
        while (trdy === 1'b1 && n < 20) begin
          n++;
          @(posedge clk);
          td <= 8'h40 + n[7:0];
          @(negedge clk);
        end
        @(posedge clk);
        tv <= 1'b0;
        filled = 1'b1;
      end
      begin
        while (!filled || i < n) begin
          host_u.recv(1'b0, 10, c, s);
          check("fifo order", 8'h40 + i[7:0], c);
          i++;
        end
      end
    join
    // Eight queued words plus the one held by the transmitter
    check("fill count", 8'h09, n[7:0]);
    check("drained ready", 8'h01, {7'h0, trdy});
  endtask
  initial begin
    t_rates();
    t_codes();
    t_fifo();
    finish_test();
  end
endmodule
